// >>> design/ltj_ctrl.sv
// Purpose: Transmit test pattern and jitter attenuator control pair.
// Assumes: Transmit and attenuator clocks arrive unsynchronised.
// Notes:   Line data leave as a single bit pair, marks on tip/ring.
`include "ltj_params.svh"
`timescale 1ns/10ps
`default_nettype none
module ltj_ctrl #(
    parameter int LOOP_LEN = 16
) (
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic       hardware_reset_n,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    output logic      [7:0] rdata,
    input  wire logic       transmit_clock,
    input  wire logic       attenuator_clock,
    input  wire logic       tx_data,
    input  wire logic       receive_carrier_loss,
    input  wire logic       receive_all_ones,
    input  wire logic       e1_t1_select,
    input  wire logic [7:0] transmit_code_def_1,
    input  wire logic [7:0] transmit_code_def_2,
    output logic            line_out_tip,
    output logic            line_out_tip_oe,
    output logic            line_out_ring,
    output logic            line_out_ring_oe,
    output logic            line_reset_pulse,
    output logic      [2:0] build_out_sel,
    output logic      [7:0] rx_sensitivity_db,
    output logic            attenuator_in_tx,
    output logic      [7:0] attenuator_depth,
    output logic            attenuator_bypass
);
    // Async pins pass two flops before use
    logic [1:0] hardware_reset_n_s_q;
    logic [1:0] transmit_clock_s_q;
    logic [1:0] jclk_s_q;
    logic [1:0] rcl_s_q;
    logic [1:0] rao_s_q;
    logic [1:0] ets_s_q;
    logic       tdat_s1_q;
    logic       tdat_s2_q;
    logic       transmit_clock_prev_q;
    logic       jclk_prev_q;
    logic       any_rst;

    always_ff @(posedge ref_clk) begin
        hardware_reset_n_s_q  <= {hardware_reset_n_s_q[0], hardware_reset_n};
        transmit_clock_s_q  <= {transmit_clock_s_q[0], transmit_clock};
        jclk_s_q  <= {jclk_s_q[0], attenuator_clock};
        rcl_s_q   <= {rcl_s_q[0], receive_carrier_loss};
        rao_s_q   <= {rao_s_q[0], receive_all_ones};
        ets_s_q   <= {ets_s_q[0], e1_t1_select};
        tdat_s1_q <= tx_data;
        tdat_s2_q <= tdat_s1_q;
        transmit_clock_prev_q <= transmit_clock_s_q[1];
        jclk_prev_q <= jclk_s_q[1];
    end

    // Pin reset acts as a level while held low
    assign any_rst = rst | ~hardware_reset_n_s_q[1]; // R12

    // Pin clocks are sampled like data: one tick per synced rising edge
    logic transmit_clock_tick;
    logic jclk_tick;
    assign transmit_clock_tick = transmit_clock_s_q[1] & ~transmit_clock_prev_q;
    assign jclk_tick = jclk_s_q[1] & ~jclk_prev_q;

    // One address compare shared by the write and read paths
    function automatic logic reg_hit(input logic [7:0] a,
                                     input logic [7:0] sel);
        return a == sel;
    endfunction

    // Register pair
    ltj_pkg::ltj_byte_t ttc_q, ttc_d, ldj_q, ldj_d;
    always_comb begin
        ttc_d = ttc_q;
        ldj_d = ldj_q;
        if (wr_en && reg_hit(addr, `LTJ_ADDR_TTC)) begin
            ttc_d = wdata;
        end
        if (wr_en && reg_hit(addr, `LTJ_ADDR_LDJ)) begin
            ldj_d = wdata;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            ttc_q <= `LTJ_RST_TTC; // R10
            ldj_q <= `LTJ_RST_LDJ; // R10
        end else begin
            ttc_q <= ttc_d;
            ldj_q <= ldj_d;
        end
    end

    // Registered read data stand for exactly one cycle per read
    logic [7:0] rdata_q, rdata_d;
    always_comb begin
        rdata_d = 8'h00;
        if (rd_en && reg_hit(addr, `LTJ_ADDR_TTC)) begin
            rdata_d = ttc_q;
        end else if (rd_en && reg_hit(addr, `LTJ_ADDR_LDJ)) begin
            rdata_d = ldj_q;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end
    assign rdata = rdata_q;

    logic ones_rel, auto_en, alt_en, prbs_en, loop_en;
    assign ones_rel = ttc_q[`LTJ_TTC_ONES_REL];
    assign auto_en  = ttc_q[`LTJ_TTC_AUTO_ONES];
    assign alt_en   = ttc_q[`LTJ_TTC_ALT];
    assign prbs_en  = ttc_q[`LTJ_TTC_PRBS];
    assign loop_en  = ttc_q[`LTJ_TTC_LOOP];

    // Edge-triggered actions
    logic line_interface_reset_bit_rise, viol_rise, berr_rise;
    ltj_edge u_edge_line_interface_reset_bit (
        .ref_clk (ref_clk),
        .rst     (any_rst),
        .level   (ttc_q[`LTJ_TTC_LINE_INTERFACE_RESET_BIT]),
        .rise    (line_interface_reset_bit_rise)
    );
    ltj_edge u_edge_viol (
        .ref_clk (ref_clk),
        .rst     (any_rst),
        .level   (ttc_q[`LTJ_TTC_VIOL]),
        .rise    (viol_rise)
    );
    ltj_edge u_edge_berr (
        .ref_clk (ref_clk),
        .rst     (any_rst),
        .level   (ttc_q[`LTJ_TTC_BERR]),
        .rise    (berr_rise)
    );
    assign line_reset_pulse = line_interface_reset_bit_rise; // R7

    // Pattern state, advanced on transmit clock ticks, or on attenuator clock ticks while ones are forced
    logic        alt_q, alt_d;
    logic [19:0] prbs_q, prbs_d;
    logic [4:0]  loop_idx_q, loop_idx_d;
    logic        viol_arm_q, viol_arm_d;
    logic        berr_arm_q, berr_arm_d;
    logic [1:0]  ones_run_q, ones_run_d;
    logic        mark_q, mark_d;
    logic        polar_q, polar_d;
    logic        bpv_q, bpv_d;
    logic        tip_q, tip_d, ring_q, ring_d;
    logic [15:0] loop_word;
    logic        fb;
    logic        bit_v;
    logic        forced;
    ltj_pkg::ltj_src_e src;

    assign loop_word = {transmit_code_def_1, transmit_code_def_2};
    assign forced = ~ones_rel | (auto_en & (rcl_s_q[1] | rao_s_q[1])); // R3

    always_comb begin
        if (~ones_rel) begin
            src = ltj_pkg::LTJ_SRC_ONES; // R1 R20
        end else if (auto_en & (rcl_s_q[1] | rao_s_q[1])) begin
            src = ltj_pkg::LTJ_SRC_ONES; // R3
        end else if (alt_en) begin
            src = ltj_pkg::LTJ_SRC_ALT;
        end else if (prbs_en) begin
            src = ltj_pkg::LTJ_SRC_PRBS;
        end else if (loop_en) begin
            src = ltj_pkg::LTJ_SRC_LOOP;
        end else begin
            src = ltj_pkg::LTJ_SRC_DATA;
        end
    end

    always_comb begin
        alt_d      = alt_q;
        prbs_d     = prbs_q;
        loop_idx_d = loop_idx_q;
        viol_arm_d = viol_arm_q | viol_rise; // R8
        berr_arm_d = berr_arm_q | berr_rise; // R9
        ones_run_d = ones_run_q;
        mark_d     = mark_q;
        polar_d    = polar_q;
        bpv_d      = 1'b0;
        tip_d      = tip_q;
        ring_d     = ring_q;
        bit_v      = 1'b1;
        fb = ets_s_q[1] ? (prbs_q[`LTJ_PRBS_T1_LEN-1] ^ prbs_q[`LTJ_PRBS_T1_TAP-1])
                        : (prbs_q[`LTJ_PRBS_E1_LEN-1] ^ prbs_q[`LTJ_PRBS_E1_TAP-1]); // R5
        // Forced ones run on attenuator ticks, patterns on transmit ticks
        if ((forced && jclk_tick) || (!forced && transmit_clock_tick)) begin // R2 R4
            unique case (src)
                ltj_pkg::LTJ_SRC_ONES: bit_v = 1'b1;
                ltj_pkg::LTJ_SRC_ALT: begin
                    bit_v = ~alt_q; // R4
                    alt_d = ~alt_q;
                end
                ltj_pkg::LTJ_SRC_PRBS: begin
                    bit_v  = prbs_q[0]; // R5
                    prbs_d = {prbs_q[18:0], fb};
                    // E1 keeps only the low stages live
                    if (!ets_s_q[1]) begin
                        prbs_d[19:`LTJ_PRBS_E1_LEN] = '0;
                    end
                end
                ltj_pkg::LTJ_SRC_LOOP: begin
                    bit_v = loop_word[4'(LOOP_LEN - 1 - int'(loop_idx_q))]; // R6
                    loop_idx_d = (int'(loop_idx_q) == LOOP_LEN - 1) ? 5'd0
                                 : 5'(loop_idx_q + 5'd1);
                end
                ltj_pkg::LTJ_SRC_DATA: bit_v = tdat_s2_q;
            endcase
            // One bit error per arming, not while ones are forced
            if (berr_arm_q && !forced) begin
                bit_v      = ~bit_v; // R9
                berr_arm_d = berr_rise;
            end
            ones_run_d = bit_v ? ((ones_run_q == 2'd3) ? 2'd3
                                  : 2'(ones_run_q + 2'd1)) : 2'd0;
            // Violation repeats the last mark polarity after two ones
            // A run already two or more ones long qualifies at once
            if (bit_v && viol_arm_q && ones_run_q[1] && !forced) begin
                bpv_d      = 1'b1; // R8
                viol_arm_d = viol_rise;
            end
            mark_d  = bit_v;
            polar_d = (bit_v && !bpv_d) ? ~polar_q : polar_q;
            tip_d   = bit_v & (bpv_d ? polar_q : ~polar_q);
            ring_d  = bit_v & ~(bpv_d ? polar_q : ~polar_q);
        end
    end

    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            alt_q      <= 1'b0;
            prbs_q     <= 20'hfffff;
            loop_idx_q <= 5'd0;
            viol_arm_q <= 1'b0;
            berr_arm_q <= 1'b0;
            ones_run_q <= 2'd0;
            mark_q     <= 1'b0;
            polar_q    <= 1'b0;
            bpv_q      <= 1'b0;
            tip_q      <= 1'b0;
            ring_q     <= 1'b0;
        end else if (line_interface_reset_bit_rise) begin
            prbs_q     <= 20'hfffff; // R7
            loop_idx_q <= 5'd0;
            ones_run_q <= 2'd0;
            alt_q      <= alt_d;
            viol_arm_q <= viol_arm_d;
            berr_arm_q <= berr_arm_d;
            mark_q     <= mark_d;
            polar_q    <= polar_d;
            bpv_q      <= bpv_d;
            tip_q      <= tip_d;
            ring_q     <= ring_d;
        end else begin
            alt_q      <= alt_d;
            prbs_q     <= prbs_d;
            loop_idx_q <= loop_idx_d;
            viol_arm_q <= viol_arm_d;
            berr_arm_q <= berr_arm_d;
            ones_run_q <= ones_run_d;
            mark_q     <= mark_d;
            polar_q    <= polar_d;
            bpv_q      <= bpv_d;
            tip_q      <= tip_d;
            ring_q     <= ring_d;
        end
    end

    // Power-down releases both line pins
    assign line_out_tip     = tip_q;
    assign line_out_ring    = ring_q;
    assign line_out_tip_oe  = ~ldj_q[`LTJ_LDJ_TPD]; // R17
    assign line_out_ring_oe = ~ldj_q[`LTJ_LDJ_TPD]; // R17

    assign build_out_sel     = ldj_q[`LTJ_LDJ_BO_HI:`LTJ_LDJ_BO_LO]; // R13
    assign attenuator_in_tx  = ldj_q[`LTJ_LDJ_PLACE]; // R14
    assign attenuator_bypass = ldj_q[`LTJ_LDJ_DIS]; // R16
    assign attenuator_depth  = ldj_q[`LTJ_LDJ_DEPTH] ? `LTJ_DEPTH_SHALLOW
                                                     : `LTJ_DEPTH_DEEP; // R15

    always_comb begin
        unique case ({ets_s_q[1], ldj_q[`LTJ_LDJ_EGL]})
            2'b00: rx_sensitivity_db = `LTJ_SENS_E1_SHORT; // R18
            2'b01: rx_sensitivity_db = `LTJ_SENS_E1_LONG; // R18
            2'b10: rx_sensitivity_db = `LTJ_SENS_T1_LONG; // R18
            2'b11: rx_sensitivity_db = `LTJ_SENS_T1_LIMITED; // R18
        endcase
    end
endmodule // ltj_ctrl
`default_nettype wire

// >>> design/ltj_edge.sv
// Purpose: Rising edge detector for one control bit.
// Assumes: Input already in this clock domain.
// Notes:   Resets its stored previous value to zero.
`timescale 1ns/10ps
`default_nettype none
module ltj_edge (
    input  wire logic ref_clk,
    input  wire logic rst,
    input  wire logic level,
    output logic      rise
);
    logic prev_q;
    logic prev_d;
    always_comb begin
        prev_d = level;
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
        end
    end
    assign rise = level & ~prev_q; // R19
endmodule // ltj_edge
`default_nettype wire

// >>> design/ltj_params.svh
// Purpose: Offsets, field positions, reset values and widths of the
//          transmit test and jitter control register pair.
// Assumes: Registers are 8 bits wide at their printed offsets.
// Notes:   The timing figures describe the bench link clock only.
// How it works
// R1: Control bit zero forces all ones out
// R2: Forced all ones timed by attenuator clock
// R3: Auto ones on carrier loss or ones
// R4: Alternating bit sends 1010 on transmit clock
// R5: PRBS 2^15-1 in E1, 2^20-1 in T1
// R6: Loop code repeats the two definition registers
// R7: Line reset rising edge recenters attenuator
// R8: Violation armed once, inserted after two ones
// R9: Bit error rising edge inverts one bit
// R10: Power-up clears writeable registers, sends ones
// R11: Host programs registers, then toggles line reset
// R12: Low hardware reset restores defaults any time
// R13: Bits 7..5 choose transmit build-out
// R14: Placement bit: receive at zero, transmit at one
// R15: Depth bit: 128 bits at zero, 32 at one
// R16: Disable bit bypasses the attenuator
// R17: Power-down bit tri-states both line outputs
// R18: Gain limit with E1/T1 picks sensitivity
// R19: Edge bits detected against registered previous value
// R20: Forced all ones beats every test pattern
`ifndef LTJ_PARAMS_SVH
`define LTJ_PARAMS_SVH
`define LTJ_ADDR_TTC        8'h02
`define LTJ_ADDR_LDJ        8'h03
`define LTJ_RST_TTC         8'h00
`define LTJ_RST_LDJ         8'h00
`define LTJ_TTC_ONES_REL    7
`define LTJ_TTC_AUTO_ONES   6
`define LTJ_TTC_ALT         5
`define LTJ_TTC_PRBS        4
`define LTJ_TTC_LOOP        3
`define LTJ_TTC_LINE_INTERFACE_RESET_BIT       2
`define LTJ_TTC_VIOL        1
`define LTJ_TTC_BERR        0
`define LTJ_LDJ_BO_HI       7
`define LTJ_LDJ_BO_LO       5
`define LTJ_LDJ_EGL         4
`define LTJ_LDJ_PLACE       3
`define LTJ_LDJ_DEPTH       2
`define LTJ_LDJ_DIS         1
`define LTJ_LDJ_TPD         0
`define LTJ_DEPTH_DEEP      8'd128
`define LTJ_DEPTH_SHALLOW   8'd32
`define LTJ_PRBS_E1_LEN     15
`define LTJ_PRBS_T1_LEN     20
`define LTJ_PRBS_E1_TAP     14
`define LTJ_PRBS_T1_TAP     17
`define LTJ_SENS_E1_SHORT   8'd12
`define LTJ_SENS_E1_LONG    8'd43
`define LTJ_SENS_T1_LONG    8'd36
`define LTJ_SENS_T1_LIMITED 8'd30
`endif

// >>> design/ltj_pkg.sv
// Purpose: Types shared by the line test and jitter control block.
// Assumes: Nothing beyond the parameter header.
// Notes:   Holds types only.
package ltj_pkg;
    typedef enum logic [2:0] {
        LTJ_SRC_DATA, LTJ_SRC_ONES, LTJ_SRC_ALT, LTJ_SRC_PRBS, LTJ_SRC_LOOP
    } ltj_src_e;
    typedef logic [7:0] ltj_byte_t;
endpackage

// >>> test/ltj_ctrl_assertions.sv
// Purpose: Port checks of the test and jitter control pair.
// Assumes: Config outputs follow a write by one cycle.
// Notes:   Bound into every ltj_ctrl.
`timescale 1ns/10ps
`default_nettype none
module ltj_ctrl_chk (
    input wire logic       ref_clk,
    input wire logic       rst,
    input wire logic       hardware_reset_n,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       e1_t1_select,
    input wire logic       line_out_tip_oe,
    input wire logic       line_out_ring_oe,
    input wire logic       line_reset_pulse,
    input wire logic [2:0] build_out_sel,
    input wire logic [7:0] rx_sensitivity_db,
    input wire logic       attenuator_in_tx,
    input wire logic [7:0] attenuator_depth,
    input wire logic       attenuator_bypass
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst || !hardware_reset_n);
    logic w2;
    logic w3;
    assign w2 = wr_en && addr == 8'h02 && wdata[2];
    assign w3 = wr_en && addr == 8'h03;
    a_build_out_write: assert property (
        w3 |=> build_out_sel == $past(wdata[7:5])) else $error("build-out");
    a_place_write: assert property (
        w3 |=> attenuator_in_tx == $past(wdata[3])) else $error("placement");
    a_depth_write: assert property (
        w3 |=> attenuator_depth == ($past(wdata[2]) ? 8'h20 : 8'h80))
        else $error("depth");
    a_bypass_write: assert property (
        w3 |=> attenuator_bypass == $past(wdata[1])) else $error("bypass");
    a_power_down_oe: assert property (
        w3 |=> {line_out_tip_oe, line_out_ring_oe} == {2{!$past(wdata[0])}})
        else $error("output enable");
    a_sens_map: assert property (
        w3 |=> rx_sensitivity_db == ($past(wdata[4])
        ? ($past(e1_t1_select) ? 8'h1e : 8'h2b)
        : ($past(e1_t1_select) ? 8'h24 : 8'h0c))) else $error("sensitivity");
    a_pulse_one_cycle: assert property (
        line_reset_pulse |=> !line_reset_pulse) else $error("pulse length");
    a_pulse_has_cause: assert property (
        line_reset_pulse |-> $past(w2) || $past(w2, 2) || $past(w2, 3))
        else $error("pulse cause");
    a_unmapped_reads_zero: assert property (
        rd_en && addr != 8'h02 && addr != 8'h03 |=> rdata == 8'h00)
        else $error("unmapped read");
    c_pulse: cover property (line_reset_pulse);
    c_power_down: cover property (w3 && wdata[0]);
    c_shallow: cover property (attenuator_depth == 8'h20);
endmodule // ltj_ctrl_chk
bind ltj_ctrl ltj_ctrl_chk u_chk (.ref_clk(ref_clk), .rst(rst),
    .hardware_reset_n(hardware_reset_n), .wr_en(wr_en), .rd_en(rd_en),
    .addr(addr), .wdata(wdata), .rdata(rdata), .e1_t1_select(e1_t1_select),
    .line_out_tip_oe(line_out_tip_oe), .line_out_ring_oe(line_out_ring_oe),
    .line_reset_pulse(line_reset_pulse), .build_out_sel(build_out_sel),
    .rx_sensitivity_db(rx_sensitivity_db), .attenuator_in_tx(attenuator_in_tx),
    .attenuator_depth(attenuator_depth), .attenuator_bypass(attenuator_bypass));
`default_nettype wire

// >>> test/ltj_framer_model.sv
// Purpose: Far-side framer that makes the line clocks and the data bit.
// Assumes: A stopped clock rests low.
// Notes:   Phases unrelated to ref_clk on purpose.
`timescale 1ns/10ps
`default_nettype none
module ltj_framer_model (
    input  wire logic tx_run,
    input  wire logic ja_run,
    input  wire logic data_bit,
    output logic      transmit_clock,
    output logic      attenuator_clock,
    output logic      tx_data
);
    initial transmit_clock = 1'b0;
    initial attenuator_clock = 1'b0;
    initial tx_data = 1'b0;
    // 320 ns transmit clock; attenuator clock a little slower
    always #160 transmit_clock = tx_run & ~transmit_clock;
    always #165 attenuator_clock = ja_run & ~attenuator_clock;
    // Data move on the falling edge, away from the rising sample
    always @(negedge transmit_clock) tx_data <= data_bit;
endmodule // ltj_framer_model
`default_nettype wire

// >>> test/test_ltj_ctrl.sv
// Purpose: Self-checking bench of the test and jitter control pair.
// Assumes: Marks are counted as rises on tip or ring.
// Notes:   Mark windows are ranges since the clocks drift.
`timescale 1ns/10ps
`default_nettype none
module test_ltj_ctrl;
    logic       ref_clk, rst, hw_rst_n, wr_en, rd_en, tx_run, ja_run;
    logic       data_bit, loss, all_ones, e1t1, tip, tip_oe, ring, ring_oe;
    logic       tck, jck, txd, pulse, in_tx, bypass;
    logic [2:0] bo;
    logic [7:0] addr, wdata, rdata, def1, def2, sens, depth, v;
    int         n_fail, checks, np, nv, rt, rr;
    always #20 ref_clk = ~ref_clk;
    // Mid-cycle sampling keeps the counters clear of the launching edge
    always @(negedge ref_clk) if (pulse === 1'b1) np++;
    // A pin held for 12 ref_clk cycles, one and a half bit times, marks a repeated polarity
    always @(negedge ref_clk) begin
        rt = (tip === 1'b1) ? rt + 1 : 0;
        rr = (ring === 1'b1) ? rr + 1 : 0;
        if (rt == 12 || rr == 12) nv++;
    end
    ltj_ctrl DUT (.ref_clk(ref_clk), .rst(rst), .hardware_reset_n(hw_rst_n),
        .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata),
        .rdata(rdata), .transmit_clock(tck), .attenuator_clock(jck),
        .tx_data(txd), .receive_carrier_loss(loss),
        .receive_all_ones(all_ones), .e1_t1_select(e1t1),
        .transmit_code_def_1(def1), .transmit_code_def_2(def2),
        .line_out_tip(tip), .line_out_tip_oe(tip_oe), .line_out_ring(ring),
        .line_out_ring_oe(ring_oe), .line_reset_pulse(pulse),
        .build_out_sel(bo), .rx_sensitivity_db(sens),
        .attenuator_in_tx(in_tx), .attenuator_depth(depth),
        .attenuator_bypass(bypass));
    ltj_framer_model u_far (.tx_run(tx_run), .ja_run(ja_run),
        .data_bit(data_bit), .transmit_clock(tck), .attenuator_clock(jck),
        .tx_data(txd));
    task automatic tick(input int n = 1);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        wr_en = 1'b1;
        addr = a;
        wdata = d;
        tick();
        wr_en = 1'b0;
        tick();
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        rd_en = 1'b1;
        addr = a;
        tick();
        rd_en = 1'b0;
        chk(rdata, e);
        tick();
    endtask
    // Settle, then count marks for n cycles against a range
    task automatic win(input int s, input int n, input int lo, input int hi);
        int c;
        logic pt, pr;
        c = 0;
        tick(s + 1);
        pt = tip;
        pr = ring;
        repeat (n) begin
            tick();
            c += int'(tip && !pt) + int'(ring && !pr);
            pt = tip;
            pr = ring;
        end
        chk({7'h00, c >= lo && c <= hi}, 8'h01);
    endtask
    task automatic t_regs();
        logic [7:0] vals [5];
        vals = '{8'hff, 8'ha5, 8'h5a, 8'h14, 8'h00};
        rdc(8'h02, 8'h00);
        rdc(8'h03, 8'h00);
        for (int t = 0; t < 2; t++) begin
            e1t1 = t[0];
            tick(5);
            foreach (vals[i]) begin
                v = vals[i];
                wr(8'h03, v);
                chk({5'h00, bo}, {5'h00, v[7:5]});
                chk({7'h00, in_tx}, {7'h00, v[3]});
                chk(depth, v[2] ? 8'h20 : 8'h80);
                chk({7'h00, bypass}, {7'h00, v[1]});
                chk({6'h00, tip_oe, ring_oe}, {6'h00, {2{~v[0]}}});
                chk(sens, v[4] ? (t ? 8'h1e : 8'h2b) : (t ? 8'h24 : 8'h0c));
                rdc(8'h03, v);
            end
        end
        e1t1 = 1'b0;
        wr(8'h07, 8'hff);
        rdc(8'h07, 8'h00);
        rdc(8'h02, 8'h00);
    endtask
    task automatic t_ones();
        win(40, 160, 15, 22);
        wr(8'h02, 8'h20);
        win(40, 160, 15, 22);
        ja_run = 1'b0;
        win(40, 160, 0, 0);
        ja_run = 1'b1;
        wr(8'h02, 8'h80);
        win(40, 160, 0, 0);
    endtask
    task automatic t_patterns();
        wr(8'h02, 8'ha0);
        win(40, 160, 8, 12);
        tx_run = 1'b0;
        win(40, 160, 0, 0);
        tx_run = 1'b1;
        for (int t = 0; t < 2; t++) begin
            e1t1 = t[0];
            // Line reset reseeds all ones, so the mark count is fixed
            wr(8'h02, 8'h90);
            wr(8'h02, 8'h94);
            win(40, t ? 320 : 360, t ? 9 : 5, t ? 9 : 5);
        end
        e1t1 = 1'b0;
        data_bit = 1'b1;
        wr(8'h02, 8'h88);
        win(40, 160, 0, 0);
        def1 = 8'hff;
        def2 = 8'hff;
        win(40, 160, 15, 22);
        data_bit = 1'b0;
        wr(8'h02, 8'hc0);
        loss = 1'b1;
        win(40, 160, 15, 22);
        loss = 1'b0;
        all_ones = 1'b1;
        win(40, 160, 15, 22);
        all_ones = 1'b0;
        win(40, 160, 0, 0);
    endtask
    task automatic t_bpv();
        def1 = 8'hff;
        def2 = 8'hff;
        wr(8'h02, 8'h88);
        tick(40);
        for (int k = 0; k < 2; k++) begin
            nv = 0;
            wr(8'h02, 8'h8a);
            tick(160);
            chk(8'(nv), k ? 8'h00 : 8'h01);
        end
    endtask
    task automatic t_edges();
        wr(8'h02, 8'h80);
        win(40, 1, 0, 1);
        wr(8'h02, 8'h81);
        // The error may land on the very next edge, so start at once
        win(-1, 160, 1, 1);
        wr(8'h02, 8'h81);
        win(0, 160, 0, 0);
        np = 0;
        wr(8'h02, 8'h84);
        tick(8);
        chk(8'(np), 8'h01);
        wr(8'h02, 8'h84);
        tick(8);
        chk(8'(np), 8'h01);
        wr(8'h02, 8'h80);
        wr(8'h02, 8'h84);
        tick(8);
        chk(8'(np), 8'h02);
    endtask
    task automatic t_hw();
        wr(8'h02, 8'hff);
        wr(8'h03, 8'hff);
        hw_rst_n = 1'b0;
        tick(4);
        hw_rst_n = 1'b1;
        tick(4);
        rdc(8'h02, 8'h00);
        rdc(8'h03, 8'h00);
        chk(depth, 8'h80);
    endtask
    task automatic end_of_test();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        {ref_clk, wr_en, rd_en, data_bit, loss, all_ones, e1t1} = '0;
        {rst, hw_rst_n, tx_run, ja_run} = 4'hf;
        {addr, wdata, def1, def2} = '0;
        {n_fail, checks, np, nv, rt, rr} = '0;
        tick(4);
        rst = 1'b0;
        tick();
        t_regs();
        t_ones();
        t_patterns();
        t_bpv();
        t_edges();
        t_hw();
        end_of_test();
    end
endmodule // test_ltj_ctrl
`default_nettype wire
